// ===== cscp_cfg.svh
`ifndef CSCP_CFG_SVH
`define CSCP_CFG_SVH
// Overview of operation
// - with shared clock and data, a device acts on shifted bits only when its own latch strobe rises.
// - in a chain the serial data output carries the oldest shifted bit so the next device shifts it in.
// - on the rising latch strobe each device takes the bits in its own shift stage and executes them at once.
// - in a chain keyboard scanning is enabled device by device, by any device that latches a system command with bit 1 set.
// - chains of any length need only shift clock, serial data and latch strobe from the host.
// - in 2-wire mode the bus address comes from the address select pin level.
// - while the manual reset input is high the device resets and asserts both reset outputs.
// - at power-up the device resets itself and shows it on both reset outputs.
// - interface select high or floating picks 4-wire mode, low picks 2-wire mode.
// - in 4-wire mode the serial data output doubles as the keyboard interrupt line.
`define CSCP_CMD_BITS 12
`define CSCP_KEY_EN_BIT 1
`define CSCP_CMD_SYS 4'h4
`define CSCP_POR_CYCLES 16'd1000
`define CSCP_ADDR_BASE 7'h30
`endif

// ===== cscp_pkg.sv
package cscp_pkg;
  typedef enum logic {CSCP_TWO_WIRE, CSCP_FOUR_WIRE} cscp_mode_t;
  typedef struct packed {
    logic [3:0] opcode;
    logic [7:0] data;
  } cscp_cmd_t;
  typedef struct packed {
    logic shift_clock;
    logic data_in;
    logic latch;
  } cscp_link_t;
endpackage : cscp_pkg

// ===== cscp_serial_port.sv
`timescale 1ns/1ps
`include "cscp_cfg.svh"
module cscp_serial_port #(
  parameter int CMD_BITS = `CSCP_CMD_BITS,
  parameter logic [15:0] POR_CYCLES = `CSCP_POR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire cscp_pkg::cscp_link_t link_in,
  input wire logic manual_reset_in,
  input wire logic interface_select,
  input wire logic addr_select,
  input wire logic key_event,
  output logic serial_out,
  output logic reset_out,
  output logic reset_out_n,
  output cscp_pkg::cscp_cmd_t cmd_out,
  output logic cmd_valid,
  output logic key_scan_en,
  output cscp_pkg::cscp_mode_t mode,
  output logic [6:0] bus_addr,
  output logic key_irq_n
);
  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [1:0] rst_meta_q;
  logic clk_prev_q;
  logic latch_prev_q;
  logic rst_req;
  always_ff @(posedge sys_clk)
  begin
    meta_q <= {link_in.shift_clock, link_in.data_in, link_in.latch};
    sync_q <= meta_q;
    rst_meta_q <= {rst_meta_q[0], manual_reset_in};
  end
  always_ff @(posedge sys_clk)
  begin
    clk_prev_q <= sync_q[2];
    latch_prev_q <= sync_q[0];
  end
  wire clk_rise = sync_q[2] & ~clk_prev_q;
  wire latch_rise = sync_q[0] & ~latch_prev_q;
  assign rst_req = rst_meta_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // strap pin synchronisers, interface select high and address select low
  logic [1:0] strap_meta_q;
  logic [1:0] strap_sync_q;
  always_ff @(posedge sys_clk)
  begin
    strap_meta_q <= {interface_select, addr_select};
    strap_sync_q <= strap_meta_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command decoding
  function automatic logic is_sys_cmd(input logic [CMD_BITS-1:0] s);
    return s[CMD_BITS-1 -: 4] == `CSCP_CMD_SYS;
  endfunction : is_sys_cmd

  ////////////////////////////////////////////////////////////////////////////////
  // power-on and manual reset
  logic [15:0] por_cnt_q;
  logic int_rst_q;
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || rst_req)
    begin
      por_cnt_q <= 16'h0000;
      int_rst_q <= 1'b1;
    end
    else if (por_cnt_q != POR_CYCLES)
    begin
      por_cnt_q <= por_cnt_q + 16'h0001;
      int_rst_q <= 1'b1;
    end
    else
      int_rst_q <= 1'b0;
  end
  always_ff @(posedge sys_clk)
  begin
    reset_out <= int_rst_q | rst_req;
    reset_out_n <= ~(int_rst_q | rst_req);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode and address straps, caught while internal reset is held
  always_ff @(posedge sys_clk)
  begin
    if (int_rst_q)
    begin
      mode <= strap_sync_q[1] ? cscp_pkg::CSCP_FOUR_WIRE : cscp_pkg::CSCP_TWO_WIRE;
      bus_addr <= `CSCP_ADDR_BASE | {6'h00, strap_sync_q[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shift stage and latch
  logic [CMD_BITS-1:0] shift_q;
  always_ff @(posedge sys_clk)
  begin
    if (int_rst_q)
    begin
      shift_q <= '0;
    end
    else if (mode == cscp_pkg::CSCP_FOUR_WIRE && clk_rise)
    begin
      shift_q <= {shift_q[CMD_BITS-2:0], sync_q[1]};
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (int_rst_q)
    begin
      cmd_valid <= 1'b0;
      cmd_out <= '0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      if (mode == cscp_pkg::CSCP_FOUR_WIRE && latch_rise)
      begin
        cmd_out <= shift_q;
        cmd_valid <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (int_rst_q)
    begin
      key_scan_en <= 1'b0;
    end
    else if (mode == cscp_pkg::CSCP_FOUR_WIRE && latch_rise && is_sys_cmd(shift_q))
    begin
      key_scan_en <= shift_q[`CSCP_KEY_EN_BIT];
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (int_rst_q)
    begin
      serial_out <= 1'b1;
      key_irq_n <= 1'b1;
    end
    else
    begin
      key_irq_n <= ~(key_scan_en & key_event);
      serial_out <= (key_scan_en && key_event) ? 1'b0 : shift_q[CMD_BITS-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  latch_takes_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!int_rst_q && mode == cscp_pkg::CSCP_FOUR_WIRE && latch_rise) |=> (cmd_valid && cmd_out == $past(shift_q)))
    else $error("latch did not take shift stage");
  no_latch_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!latch_rise) |=> !cmd_valid)
    else $error("command without latch strobe");
  manual_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rst_req |=> ##1 (reset_out && !reset_out_n))
    else $error("manual reset not shown");
  reset_pair_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reset_out == !reset_out_n)
    else $error("reset outputs disagree");
  shift_chain_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!int_rst_q && clk_rise && mode == cscp_pkg::CSCP_FOUR_WIRE) |=> shift_q[0] == $past(sync_q[1]))
    else $error("bit not shifted in");
  addr_pin_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    int_rst_q |=> bus_addr[0] == $past(strap_sync_q[0]))
    else $error("address not from pin");
  mode_pin_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    int_rst_q |=> (mode == cscp_pkg::CSCP_FOUR_WIRE) == $past(strap_sync_q[1]))
    else $error("mode not from pin");
  key_irq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!int_rst_q && key_scan_en && key_event) |=> (!serial_out && !key_irq_n))
    else $error("key interrupt missing");

  valid_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  two_wire_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == cscp_pkg::CSCP_TWO_WIRE) |=> !cmd_valid)
    else $error("command in 2-wire mode");
  two_wire_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == cscp_pkg::CSCP_TWO_WIRE && !int_rst_q) |=> $stable(shift_q))
    else $error("shift stage moved in 2-wire mode");
  cmd_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!int_rst_q && !(mode == cscp_pkg::CSCP_FOUR_WIRE && latch_rise)) |=> $stable(cmd_out))
    else $error("command changed without latch strobe");
  key_en_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!int_rst_q && !(mode == cscp_pkg::CSCP_FOUR_WIRE && latch_rise)) |=> $stable(key_scan_en))
    else $error("key enable changed without latch strobe");
  chain_out_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!int_rst_q && !(key_scan_en && key_event)) |=> serial_out == $past(shift_q[CMD_BITS-1]))
    else $error("serial output not oldest bit");
  por_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (por_cnt_q != POR_CYCLES) |=> int_rst_q)
    else $error("internal reset ended early");
  reset_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    int_rst_q |=> reset_out)
    else $error("reset output not shown");
  manual_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rst_req |=> int_rst_q)
    else $error("manual reset not taken");
  mode_steady_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !int_rst_q |=> $stable(mode))
    else $error("mode changed outside reset");
  irq_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !key_scan_en |=> key_irq_n)
    else $error("key interrupt while scanning off");

  ////////////////////////////////////////////////////////////////////////////////
  // cover points
  cover_latch_c: cover property (@(posedge sys_clk) disable iff (!reset_n) cmd_valid);
  cover_two_wire_c: cover property (@(posedge sys_clk) disable iff (!reset_n) mode == cscp_pkg::CSCP_TWO_WIRE);
  cover_key_en_c: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(key_scan_en));
  cover_key_c: cover property (@(posedge sys_clk) disable iff (!reset_n) !key_irq_n);
  cover_rst_c: cover property (@(posedge sys_clk) disable iff (!reset_n) rst_req ##1 !rst_req);
endmodule : cscp_serial_port

// ===== cscp_host_model.sv
`timescale 1ns/1ps
module cscp_host_model (
  input wire logic sys_clk,
  output cscp_pkg::cscp_link_t link
);
  initial link = 3'h0;
  task automatic half();
    repeat (10) @(posedge sys_clk);
  endtask : half
  // msb first; clock idles low, released data shows inverse
  task automatic shift(input logic [11:0] w);
    for (int i = 11; i >= 0; i--)
    begin
      link.data_in <= w[i];
      half();
      link.shift_clock <= 1'b1;
      half();
      link.shift_clock <= 1'b0;
    end
    link.data_in <= ~w[0];
    half();
  endtask : shift
  // one rising strobe for the whole chain
  task automatic latch();
    half();
    link.latch <= 1'b1;
    half();
    link.latch <= 1'b0;
  endtask : latch
endmodule : cscp_host_model

// ===== cascadable_serial_command_port_test.sv
`timescale 1ns/1ps
module cascadable_serial_command_port_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic manual_reset_in = 1'b0;
  logic interface_select = 1'b1;
  logic addr_select = 1'b1;
  logic key_event = 1'b0;
  logic serial_out, reset_out, reset_out_n, cmd_valid, key_scan_en, key_irq_n;
  logic [6:0] bus_addr;
  cscp_pkg::cscp_link_t link;
  cscp_pkg::cscp_cmd_t cmd_out, w;
  cscp_pkg::cscp_mode_t mode;
  int miscompares = 0;
  int n_checks = 0;
  int n_valid = 0;
  int ev = 0;
  int seed = 32'h7b42aa2a;
  cscp_serial_port #(.POR_CYCLES(16'd20)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .link_in(link),
    .manual_reset_in(manual_reset_in), .interface_select(interface_select), .addr_select(addr_select),
    .key_event(key_event), .serial_out(serial_out), .reset_out(reset_out), .reset_out_n(reset_out_n),
    .cmd_out(cmd_out), .cmd_valid(cmd_valid), .key_scan_en(key_scan_en), .mode(mode), .bus_addr(bus_addr),
    .key_irq_n(key_irq_n));
  cscp_host_model host (.sys_clk(sys_clk), .link(link));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cmd_valid === 1'b1) n_valid++;
  ////////////////////////////////////////////////////////////////
  function automatic logic [6:0] exp_addr(input logic a);
    return 7'h30 | {6'h00, a};
  endfunction : exp_addr
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : check
  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic ready();
    for (int i = 0; i < 200 && reset_out_n !== 1'b1; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask : ready
  task automatic do_reset(input logic sel);
    reset_n <= 1'b0;
    interface_select <= sel;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(reset_out, 1'b1);
    check(reset_out_n, 1'b0);
    ready();
  endtask : do_reset
  task automatic op(input logic [11:0] far, input logic [11:0] near);
    host.shift(far);
    host.shift(near);
    host.latch();
    ev++;
    repeat (4) @(posedge sys_clk);
    check(cmd_out, near);
    check(serial_out, near[11]);
    check(n_valid, ev);
  endtask : op
  ////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset(1'b1);
    check(mode, cscp_pkg::CSCP_FOUR_WIRE);
    check(bus_addr, exp_addr(1'b1));
    repeat (6)
    begin
      w = $random(seed);
      w.opcode = w.opcode ^ {3'h0, w.opcode == 4'h4};
      op($random(seed), w);
    end
    host.shift(12'hffe);
    repeat (6) @(posedge sys_clk);
    check(cmd_out, w);
    check(n_valid, ev);
    op(12'h5a5, {4'h4, 8'h02});
    check(key_scan_en, 1'b1);
    op(12'h5a5, {4'h4, 8'h02});
    check(key_scan_en, 1'b1);
    key_event <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(serial_out, 1'b0);
    check(key_irq_n, 1'b0);
    key_event <= 1'b0;
    addr_select <= 1'b0;
    manual_reset_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check({reset_out, reset_out_n, key_scan_en}, 3'h4);
    manual_reset_in <= 1'b0;
    ready();
    check(bus_addr, exp_addr(1'b0));
    do_reset(1'b0);
    check(mode, cscp_pkg::CSCP_TWO_WIRE);
    host.shift(12'h402);
    host.latch();
    repeat (4) @(posedge sys_clk);
    check(n_valid, ev);
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
endmodule : cascadable_serial_command_port_test
